// ==== hw/lpss_pkg.sv ====
// Constants, states and carrier structs for the low-power state sequencer.
// Assumes a single 25 MHz clock domain; pins are synchronised in the top.
//
// How it works
// - The sequencer offers active, sleep and deep-sleep modes besides off.
// - A low chip enable holds the device off with everything at reset values but pad_oe_hold_n, which pad_hold_en pulls low.
// - In deep-sleep only the timekeeping domain keeps power.
// - The retention memory in the timekeeping domain keeps its words in deep-sleep.
// - In sleep only timekeeping runs and the oscillator enable is low.
// - Any wake source in sleep moves the sequencer to wake-up.
// - Entering wake-up turns on the oscillator and the PLLs.
// - Wake-up proceeds to the powered run state.
// - In the on state block clocks follow the clock control enables.
// - Each block may also gate its own clock locally.
// - A wait-for-interrupt instruction gates the CPU clock until an interrupt.
// - A power-down hold option forces all pad output enables to the held state.
// - A high chip enable allows operation, a low one turns the chip off.
// - The external reset input is active low and resets the chip while low.
package lpss_pkg;

   localparam int unsigned NUM_BLOCKS = 8;
   localparam int unsigned NUM_WAKE   = 4;
   localparam int unsigned RET_DEPTH  = 16;
   localparam int unsigned RET_AW     = 4;
   localparam int unsigned RET_DW     = 32;

   // Wake source bit positions
   localparam int unsigned WAKE_MAC   = 0;
   localparam int unsigned WAKE_HOST  = 1;
   localparam int unsigned WAKE_TIMER = 2;
   localparam int unsigned WAKE_EXT   = 3;

   localparam logic [NUM_BLOCKS-1:0] BLK_OFF  = 8'h00;
   localparam logic [RET_DW-1:0]     RET_ZERO = 32'h0000_0000;

   typedef enum logic [2:0] {
      LPSS_OFF,
      LPSS_ON,
      LPSS_SLEEP,
      LPSS_DEEP,
      LPSS_WAKE
   } lpss_state_t;

   typedef struct packed {
      logic osc_en;
      logic pll_en;
      logic main_pwr_en;
      logic rtc_en;
      logic deep_wake;
   } lpss_pwr_t;

   typedef struct packed {
      logic              wr;
      logic [RET_AW-1:0] addr;
      logic [RET_DW-1:0] wdata;
   } lpss_ret_req_t;

endpackage

// ==== hw/lpss_sequencer.sv ====
// Low-power state sequencer: power state machine, clock gating enables,
// CPU wait gating, pad hold and retention memory.
// Assumes pins and lock flags arrive asynchronously; CPU-side requests
// come from logic on clk.
`timescale 1ns/10ps
`default_nettype none

module lpss_sequencer (
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   input  wire logic                           clk_en,
   input  wire logic                           chip_enable_pin,
   input  wire logic                           external_reset_n,
   input  wire logic [lpss_pkg::NUM_WAKE-1:0]  wake_src,
   input  wire logic                           osc_lock,
   input  wire logic                           pll_lock,
   input  wire logic                           sleep_req,
   input  wire logic                           deep_sleep_req,
   input  wire logic                           timer_expired,
   input  wire logic [lpss_pkg::NUM_BLOCKS-1:0] clk_ctrl,
   input  wire logic [lpss_pkg::NUM_BLOCKS-1:0] blk_local_en,
   input  wire logic                           wait_for_interrupt_instruction,
   input  wire logic                           cpu_irq,
   input  wire logic                           pad_hold_en,
   input  wire lpss_pkg::lpss_ret_req_t        ret_req,
   output logic [lpss_pkg::RET_DW-1:0]         ret_rdata,
   output lpss_pkg::lpss_pwr_t                 powered_run_state,
   output logic [lpss_pkg::NUM_BLOCKS-1:0]     blk_clk_en,
   output logic                                cpu_clk_en,
   output logic                                pad_oe_hold_n,
   output logic                                deep_sleep_wake_output,
   output lpss_pkg::lpss_state_t               state
);
   import lpss_pkg::*;

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   localparam int unsigned SYN_W = NUM_WAKE + 4;
   logic [SYN_W-1:0] syn1_reg;
   logic [SYN_W-1:0] syn2_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syn1_reg <= '0;
         syn2_reg <= '0;
      end else if (clk_en) begin
         syn1_reg <= {chip_enable_pin, external_reset_n, osc_lock,
                      pll_lock, wake_src};
         syn2_reg <= syn1_reg;
      end
   end

   wire                chip_on_s = syn2_reg[SYN_W-1];
   wire                ext_rst_s = syn2_reg[SYN_W-2];
   wire                osc_lk_s  = syn2_reg[SYN_W-3];
   wire                pll_lk_s  = syn2_reg[SYN_W-4];
   wire [NUM_WAKE-1:0] wake_s    = syn2_reg[NUM_WAKE-1:0];

   // Off while enable is low or the reset pin is held
   wire chip_off  = !chip_on_s;
   wire chip_rst  = chip_off || !ext_rst_s;
   wire any_wake  = |wake_s;
   wire locked    = osc_lk_s && pll_lk_s;

   // ==========================================================
   // Power state machine
   // ==========================================================
   lpss_state_t state_reg;
   lpss_state_t state_next;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         LPSS_OFF:   state_next = LPSS_WAKE;
         LPSS_WAKE:  if (locked) state_next = LPSS_ON;
         LPSS_ON: begin
            // Wake pulses here do nothing
            if (deep_sleep_req)  state_next = LPSS_DEEP;
            else if (sleep_req)  state_next = LPSS_SLEEP;
         end
         LPSS_SLEEP: if (any_wake) state_next = LPSS_WAKE;
         // Deep-sleep leaves only via chip_rst: the external reset loop or a low chip enable
         LPSS_DEEP:  state_next = LPSS_DEEP;
         default:    state_next = LPSS_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         state_reg <= LPSS_OFF;
      else if (clk_en) begin
         if (chip_rst)
            state_reg <= LPSS_OFF;
         else
            state_reg <= state_next;
      end
   end

   // ==========================================================
   // Output decode
   // ==========================================================
   wire in_on    = (state_next == LPSS_ON);
   wire in_wake  = (state_next == LPSS_WAKE);
   wire in_deep  = (state_next == LPSS_DEEP);
   wire live     = !chip_rst;

   lpss_pwr_t pwr_next;
   assign pwr_next = '{
      osc_en:      live && (in_wake || in_on),
      pll_en:      live && (in_wake || in_on),
      main_pwr_en: live && !in_deep,
      rtc_en:      chip_on_s,
      deep_wake:   live && in_deep && timer_expired
   };

   // System gate and local gate both needed
   wire [NUM_BLOCKS-1:0] blk_next =
      (live && in_on) ? (clk_ctrl & blk_local_en) : BLK_OFF;

   // ==========================================================
   // CPU wait gating
   // ==========================================================
   logic wfi_reg;
   logic wfi_next;
   assign wfi_next = (!live || !in_on || cpu_irq) ? 1'b0
                   : (wfi_reg || wait_for_interrupt_instruction);

   // ==========================================================
   // Output registers
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         powered_run_state           <= '0;
         blk_clk_en    <= BLK_OFF;
         wfi_reg       <= 1'b0;
         cpu_clk_en    <= 1'b0;
         pad_oe_hold_n <= 1'b1;
      end else if (clk_en) begin
         powered_run_state           <= pwr_next;
         blk_clk_en    <= blk_next;
         wfi_reg       <= wfi_next;
         cpu_clk_en    <= live && in_on && !wfi_next;
         // Hold only when powered down; active low while holding
         pad_oe_hold_n <= !(pad_hold_en && !(live && in_on));
      end
   end

   assign state                  = state_reg;
   assign deep_sleep_wake_output = powered_run_state.deep_wake;

   // ==========================================================
   // Retention memory
   // ==========================================================
   // Kept across deep-sleep; only clearing while chip_off, since the power-loss
   // of the chip enable must wipe every register.
   logic [RET_DW-1:0] ret_mem [RET_DEPTH];
   wire ret_wr = ret_req.wr && live && (state_reg == LPSS_ON);

   genvar gi;
   generate
      for (gi = 0; gi < RET_DEPTH; gi++) begin : g_ret
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n)
               ret_mem[gi] <= RET_ZERO;
            else if (clk_en) begin
               if (chip_off)
                  ret_mem[gi] <= RET_ZERO;
               else if (ret_wr && ret_req.addr == RET_AW'(gi))
                  ret_mem[gi] <= ret_req.wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ret_rdata <= RET_ZERO;
      else if (clk_en)
         ret_rdata <= ret_mem[ret_req.addr];
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_sleeping_wake;
      (state_reg == LPSS_SLEEP) && any_wake && !chip_rst && clk_en;
   endsequence

   a_off_when_disabled: assert property (
      (chip_off && clk_en) |=> (state_reg == LPSS_OFF))
      else $error("not off while chip enable low");
   a_reset_forces_off: assert property (
      (!ext_rst_s && clk_en) |=> (state_reg == LPSS_OFF))
      else $error("not off while reset held");
   a_sleep_wakes: assert property (
      s_sleeping_wake |=> (state_reg == LPSS_WAKE))
      else $error("wake event lost in sleep");
   a_wake_osc_on: assert property (
      (state_reg == LPSS_WAKE) |-> powered_run_state.osc_en && powered_run_state.pll_en)
      else $error("osc or pll off in wake-up");
   a_sleep_osc_off: assert property (
      (state_reg == LPSS_SLEEP) |-> !powered_run_state.osc_en)
      else $error("oscillator on in sleep");
   a_lock_before_on: assert property (
      ($rose(state_reg == LPSS_ON)) |-> $past(locked))
      else $error("on entered before lock");
   a_deep_power_off: assert property (
      (state_reg == LPSS_DEEP) |-> !powered_run_state.main_pwr_en && powered_run_state.rtc_en)
      else $error("main power on in deep-sleep");
   // A frozen cycle keeps the old gates, so only judge advanced cycles
   a_blk_clk_gated: assert property (
      ((blk_clk_en != BLK_OFF) && $past(clk_en)) |->
         ((blk_clk_en & ~($past(clk_ctrl) & $past(blk_local_en)))
          == BLK_OFF))
      else $error("block clock without enable");
   a_on_ignores_wake: assert property (
      (state_reg == LPSS_ON && any_wake && !sleep_req && !deep_sleep_req
       && !chip_rst && clk_en) |=> (state_reg == LPSS_ON))
      else $error("wake restarted sequence");
   a_wfi_gates_cpu: assert property (
      (state_reg == LPSS_ON && wait_for_interrupt_instruction && !cpu_irq
       && clk_en && !chip_rst) |=> !cpu_clk_en)
      else $error("cpu clock not gated by wait");

endmodule

`default_nettype wire

// ==== bench/lpss_partner.sv ====
// Far side of the sequencer: pins, wake sources and lock flags.
// Assumes the bench changes its commands at the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Board model
module lpss_partner (
   input  wire logic                         clk,
   input  wire logic                         chip_on,
   input  wire logic                         rst_cmd_n,
   input  wire logic [lpss_pkg::NUM_WAKE-1:0] wake_cmd,
   input  wire logic                         osc_en,
   input  wire logic                         pll_en,
   input  wire logic                         deep_wake,
   output logic                              chip_enable_pin,
   output logic                              external_reset_n,
   output logic [lpss_pkg::NUM_WAKE-1:0]     wake_src,
   output logic                              osc_lock,
   output logic                              pll_lock
);
   logic [2:0] lock_dly;
   assign chip_enable_pin = chip_on;
   // Wake output wired to the reset pin, so a pulse restarts the chip
   assign external_reset_n = rst_cmd_n & ~deep_wake;
   assign wake_src = wake_cmd;
   // Locks lag the enables by a few cycles but drop at once
   always_ff @(posedge clk) lock_dly <= {lock_dly[1:0], osc_en & pll_en};
   assign osc_lock = lock_dly[2] & osc_en;
   assign pll_lock = lock_dly[1] & pll_en;
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench: boot, gating, CPU wait, sleep, deep-sleep, off.
// Assumes lpss_pkg and lpss_partner are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
 miscompares++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
   import lpss_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, chip_on = 1'b1, rst_cmd_n = 1'b1;
   logic sleep_req = 1'b0, deep_req = 1'b0, tmr = 1'b0, wfi = 1'b0;
   logic irq = 1'b0, hold = 1'b0, cep, ern, ol, pl, cpu_en, hold_n, dwo;
   logic [NUM_WAKE-1:0]   wake_cmd = '0, wake_src;
   logic [NUM_BLOCKS-1:0] ctrl = 8'ha5, loc = 8'h3c, blk;
   logic [RET_DW-1:0]     rdata;
   lpss_ret_req_t         req = '0;
   lpss_pwr_t             powered_run_state;
   lpss_state_t           state;
   int                    miscompares = 0, check_count = 0;
   initial begin
      forever #20 clk = ~clk;
   end
   lpss_partner partner (.clk(clk), .chip_on(chip_on),
      .rst_cmd_n(rst_cmd_n), .wake_cmd(wake_cmd), .osc_en(powered_run_state.osc_en),
      .pll_en(powered_run_state.pll_en), .deep_wake(dwo), .chip_enable_pin(cep),
      .external_reset_n(ern), .wake_src(wake_src), .osc_lock(ol),
      .pll_lock(pl));
   lpss_sequencer dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
      .chip_enable_pin(cep), .external_reset_n(ern), .wake_src(wake_src),
      .osc_lock(ol), .pll_lock(pl), .sleep_req(sleep_req),
      .deep_sleep_req(deep_req), .timer_expired(tmr), .clk_ctrl(ctrl),
      .blk_local_en(loc), .wait_for_interrupt_instruction(wfi),
      .cpu_irq(irq), .pad_hold_en(hold), .ret_req(req), .ret_rdata(rdata),
      .powered_run_state(powered_run_state), .blk_clk_en(blk), .cpu_clk_en(cpu_en),
      .pad_oe_hold_n(hold_n), .deep_sleep_wake_output(dwo), .state(state));
   // ============================================================
   // Shared tasks
   task automatic stop_test();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bounded wait; a missed state ends the run
   task automatic go(input lpss_state_t s);
      int i;
      for (i = 0; i < 80 && state !== s; i++) @(negedge clk);
      `CHK("state", s, state)
      if (state !== s) stop_test();
   endtask
   task automatic rd(input logic [RET_DW-1:0] e);
      req = '{1'b0, 4'h5, 32'h0};
      tick(2);
      `CHK("ret_rdata", e, rdata)
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   // ============================================================
   // Scenarios
   task automatic t_boot();
      go(LPSS_WAKE);
      `CHK("osc_pll", 2'b11, {powered_run_state.osc_en, powered_run_state.pll_en})
      `CHK("locked", 1'b0, ol & pl)
      go(LPSS_ON);
      `CHK("locked", 1'b1, ol & pl)
      `CHK("cpu_clk_en", 1'b1, cpu_en)
      `CHK("blk_clk_en", 8'h24, blk)
      loc = 8'hff;
      tick(2);
      `CHK("blk_clk_en", 8'ha5, blk)
   endtask
   task automatic t_cpu();
      pulse(wfi);
      tick(3);
      `CHK("cpu_clk_en", 1'b0, cpu_en)
      pulse(irq);
      `CHK("cpu_clk_en", 1'b1, cpu_en)
      req = '{1'b1, 4'h5, 32'hcafe_0123};
      tick(1);
      rd(32'hcafe_0123);
      wake_cmd = 4'hf;
      tick(6);
      `CHK("state", LPSS_ON, state)
      wake_cmd = '0;
      // Let the synchronised wake drain, or sleep would end at once
      tick(2);
   endtask
   task automatic t_sleep();
      int k;
      hold = 1'b1;
      for (k = 0; k < NUM_WAKE; k++) begin
         pulse(sleep_req);
         go(LPSS_SLEEP);
         `CHK("osc_rtc", 2'b01, {powered_run_state.osc_en, powered_run_state.rtc_en})
         `CHK("pad_oe_hold_n", 1'b0, hold_n)
         tick(3);
         `CHK("state", LPSS_SLEEP, state)
         wake_cmd = 4'h1 << k;
         go(LPSS_WAKE);
         `CHK("osc_pll", 2'b11, {powered_run_state.osc_en, powered_run_state.pll_en})
         wake_cmd = '0;
         go(LPSS_ON);
         `CHK("pad_oe_hold_n", 1'b1, hold_n)
      end
      hold = 1'b0;
   endtask
   task automatic t_deep();
      pulse(deep_req);
      go(LPSS_DEEP);
      `CHK("main_rtc", 2'b01, {powered_run_state.main_pwr_en, powered_run_state.rtc_en})
      wake_cmd = 4'h1;
      tick(6);
      `CHK("state", LPSS_DEEP, state)
      wake_cmd = '0;
      pulse(tmr);
      `CHK("deep_wake", 1'b1, dwo)
      go(LPSS_OFF);
      go(LPSS_ON);
      rd(32'hcafe_0123);
      rst_cmd_n = 1'b0;
      go(LPSS_OFF);
      `CHK("blk_clk_en", BLK_OFF, blk)
      rst_cmd_n = 1'b1;
      go(LPSS_ON);
      chip_on = 1'b0;
      go(LPSS_OFF);
      `CHK("rtc_en", 1'b0, powered_run_state.rtc_en)
      chip_on = 1'b1;
      go(LPSS_ON);
      rd(RET_ZERO);
   endtask
   initial begin
      tick(5);
      rst_n = 1'b1;
      t_boot();
      t_cpu();
      t_sleep();
      t_deep();
      stop_test();
   end
endmodule
`default_nettype wire
